// ==== hdl/eds_decode.sv ====
`timescale 1ns/1ns
module eds_decode
  import eds_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  // special-function register port from the core
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic SFR_WR_I,
  input wire logic SFR_RD_I,
  input wire logic [7:0] SFR_WDATA_I,
  output logic [7:0] SFR_RDATA_O,
  // mode inputs
  input wire logic COMPAT_MODE_I,
  input wire logic NV_WINDOW_ENABLE_I,
  input wire logic [7:0] P2_LATCH_I,
  // external-data move requests
  input wire logic XREQ_I,
  input wire logic XWIDE_I,
  input wire logic XWR_I,
  input wire logic [15:0] XADDR16_I,
  input wire logic [7:0] XADDR8_I,
  input wire logic [7:0] XWDATA_I,
  output logic XDONE_O,
  output logic [7:0] XRDATA_O,
  // stack operations
  input wire logic STK_REQ_I,
  input wire logic STK_PUSH_I,
  input wire logic [7:0] STK_WDATA_I,
  output logic STK_DONE_O,
  output logic [7:0] STK_RDATA_O,
  output logic READY_O,
  // internal indirect space port for the default stack
  output logic INTERNAL_INDIRECT_SPACE_REQ_O,
  output logic INTERNAL_INDIRECT_SPACE_WE_O,
  output logic [7:0] INTERNAL_INDIRECT_SPACE_ADDR_O,
  output logic [7:0] INTERNAL_INDIRECT_SPACE_WDATA_O,
  input wire logic [7:0] INTERNAL_INDIRECT_SPACE_RDATA_I,
  // external data space
  output logic [15:0] EXT_ADDR_O,
  output logic EXT_RD_N_O,
  output logic EXT_WR_N_O,
  output logic [7:0] EXT_DATA_O,
  output logic EXT_DATA_OE_O,
  input wire logic [7:0] EXT_DATA_I
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] aux_control_ff;
  logic ext_stack_enable_ff;
  logic [7:0] aux_internal_ram_page_select_ff;
  logic [7:0] stack_ptr_low_ff;
  logic [2:0] stack_ptr_high_ff;
  logic [7:0] sfr_rdata_ff;
  eds_state_e state_ff;
  eds_state_e nxt_state;
  logic [15:0] addr_ff;
  logic [7:0] wdata_ff;
  logic wr_ff;
  logic tgt_ext_ff;
  logic tgt_stk_ff;
  logic tgt_ext_stack_enable_ff;
  logic [7:0] rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // register fields and decoding
  logic wait_state_sel_hi;
  logic wait_state_sel_lo;
  logic [1:0] ws_eff;
  logic [2:0] aux_ram_size_sel;
  logic internal_ram_bypass;
  logic [11:0] size_lim;
  logic [3:0] strobe_len;
  logic [10:0] paged_addr;
  logic page_in_range;
  logic wide_hit;
  logic paged_hit;
  logic mv_internal;
  logic [15:0] mv_addr;
  logic acc_stk;
  logic acc_mv;
  logic [10:0] xptr;
  logic [10:0] xptr_next;
  logic [7:0] sp_next;
  logic [15:0] stk_addr;

  assign wait_state_sel_hi = aux_control_ff[WS1_BIT] & ~COMPAT_MODE_I;
  assign wait_state_sel_lo = aux_control_ff[WS0_BIT];
  assign ws_eff = {wait_state_sel_hi, wait_state_sel_lo};
  assign aux_ram_size_sel = aux_control_ff[XRS_LSB+2:XRS_LSB];
  assign internal_ram_bypass = aux_control_ff[BYPASS_BIT];

  // reserved size codes leave no internal range, so nothing aliases
  assign size_lim = (aux_ram_size_sel == XRS_256) ? SZ_256 :
                    (aux_ram_size_sel == XRS_512) ? SZ_512 :
                    (aux_ram_size_sel == XRS_768) ? SZ_768 :
                    (aux_ram_size_sel == XRS_1024) ? SZ_1024 :
                    (aux_ram_size_sel == XRS_1152) ? SZ_1152 : SZ_NONE;

  // fast mode: base strobe plus wait states; compat mode fixed widths
  assign strobe_len = COMPAT_MODE_I ?
                      (wait_state_sel_lo ? STB_COMPAT_WS1 : STB_COMPAT_WS0) :
                      STB_FAST_BASE + {2'h0, ws_eff};

  // one shared page for both indirect registers
  assign paged_addr = {aux_internal_ram_page_select_ff[2:0], XADDR8_I};
  assign page_in_range = aux_internal_ram_page_select_ff <= PAGE_MAX;
  assign wide_hit = ~internal_ram_bypass & ~NV_WINDOW_ENABLE_I &
                    (XADDR16_I < {4'h0, size_lim});
  assign paged_hit = ~internal_ram_bypass & page_in_range &
                     ({1'b0, paged_addr} < size_lim);
  assign mv_internal = XWIDE_I ? wide_hit : paged_hit;
  // external paged moves keep port 2 as the upper byte
  assign mv_addr = XWIDE_I ? XADDR16_I :
                   mv_internal ? {5'h00, paged_addr} :
                   {P2_LATCH_I, XADDR8_I};

  assign acc_stk = (state_ff == S_IDLE) & STK_REQ_I;
  assign acc_mv = (state_ff == S_IDLE) & XREQ_I & ~STK_REQ_I;

  // combined pointer moves as one value, carry crosses into high bits
  assign xptr = {stack_ptr_high_ff, stack_ptr_low_ff};
  assign xptr_next = STK_PUSH_I ? xptr + 11'h001 : xptr - 11'h001;
  // internal stack wraps inside 8 bits and never touches the high part
  assign sp_next = STK_PUSH_I ? stack_ptr_low_ff + 8'h01 :
                   stack_ptr_low_ff - 8'h01;
  // push writes at the new pointer, pop reads at the old one
  assign stk_addr = ext_stack_enable_ff ?
                    {5'h00, (STK_PUSH_I ? xptr_next : xptr)} :
                    {8'h00, (STK_PUSH_I ? sp_next : stack_ptr_low_ff)};

  ////////////////////////////////////////////////////////////////////////////
  // special-function registers
  logic wr_aux;
  logic wr_aux2;
  logic wr_page;
  logic wr_spx;
  logic wr_sp;
  logic [7:0] sfr_rd_mux;
  logic [7:0] aux_rd_view;

  assign wr_aux = SFR_WR_I & (SFR_ADDR_I == SFR_AUX_CTRL);
  assign wr_aux2 = SFR_WR_I & (SFR_ADDR_I == SFR_AUX_CTRL2);
  assign wr_page = SFR_WR_I & (SFR_ADDR_I == SFR_PAGE);
  assign wr_spx = SFR_WR_I & (SFR_ADDR_I == SFR_SPX);
  assign wr_sp = SFR_WR_I & (SFR_ADDR_I == SFR_SP);
  assign aux_rd_view = {aux_control_ff[7], wait_state_sel_hi,
                        aux_control_ff[5:0]};
  assign sfr_rd_mux =
    (SFR_ADDR_I == SFR_AUX_CTRL) ? aux_rd_view :
    (SFR_ADDR_I == SFR_AUX_CTRL2) ? {3'h0, ext_stack_enable_ff, 4'h0} :
    (SFR_ADDR_I == SFR_PAGE) ? aux_internal_ram_page_select_ff :
    (SFR_ADDR_I == SFR_SPX) ? {5'h00, stack_ptr_high_ff} :
    (SFR_ADDR_I == SFR_SP) ? stack_ptr_low_ff : 8'h00;

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      aux_control_ff <= AUX_CTRL_RST;
      ext_stack_enable_ff <= 1'b0;
      aux_internal_ram_page_select_ff <= PAGE_RST;
      sfr_rdata_ff <= 8'h00;
    end else begin
      if (wr_aux) aux_control_ff <= SFR_WDATA_I;
      if (wr_aux2) ext_stack_enable_ff <= SFR_WDATA_I[EXT_STACK_ENABLE_BIT];
      if (wr_page) aux_internal_ram_page_select_ff <= SFR_WDATA_I;
      if (SFR_RD_I) sfr_rdata_ff <= sfr_rd_mux;
    end
  end

  // a stack operation accepted in the same cycle wins over a software write
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      stack_ptr_low_ff <= SP_RST;
      stack_ptr_high_ff <= SPX_RST;
    end else if (acc_stk && ext_stack_enable_ff) begin
      {stack_ptr_high_ff, stack_ptr_low_ff} <= xptr_next;
    end else if (acc_stk) begin
      stack_ptr_low_ff <= sp_next;
    end else begin
      if (wr_sp) stack_ptr_low_ff <= SFR_WDATA_I;
      if (wr_spx) stack_ptr_high_ff <= SFR_WDATA_I[2:0];
    end
  end

  assign SFR_RDATA_O = sfr_rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // access sequencer
  logic cnt_last;
  logic [7:0] ram_rdata;
  logic ram_en;

  eds_wait_cnt #(.W(4)) u_wait (
    .clk_i(SYS_CLK_I),
    .rstn_i(RSTN_I),
    .load_i(acc_mv),
    .load_val_i(strobe_len),
    .run_i(state_ff == S_XSTB),
    .last_o(cnt_last)
  );

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      S_IDLE: begin
        if (acc_stk && ext_stack_enable_ff) nxt_state = S_PEN;
        else if (acc_stk) nxt_state = S_IDAT;
        else if (acc_mv && mv_internal) nxt_state = S_RAM;
        else if (acc_mv) nxt_state = S_XSTB;
      end
      S_PEN: nxt_state = S_RAM;
      S_RAM: nxt_state = S_CAP;
      S_IDAT: nxt_state = S_CAP;
      S_CAP: nxt_state = S_DONE;
      S_XSTB: begin
        if (cnt_last) nxt_state = S_DONE;
      end
      S_DONE: nxt_state = S_IDLE;
      default: nxt_state = S_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_ff <= S_IDLE;
      addr_ff <= 16'h0000;
      wdata_ff <= 8'h00;
      wr_ff <= 1'b0;
      tgt_ext_ff <= 1'b0;
      tgt_stk_ff <= 1'b0;
      tgt_ext_stack_enable_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (acc_stk) begin
        addr_ff <= stk_addr;
        wdata_ff <= STK_WDATA_I;
        wr_ff <= STK_PUSH_I;
        tgt_ext_ff <= 1'b0;
        tgt_stk_ff <= 1'b1;
        tgt_ext_stack_enable_ff <= ext_stack_enable_ff;
      end else if (acc_mv) begin
        addr_ff <= mv_addr;
        wdata_ff <= XWDATA_I;
        wr_ff <= XWR_I;
        tgt_ext_ff <= ~mv_internal;
        tgt_stk_ff <= 1'b0;
        tgt_ext_stack_enable_ff <= 1'b0;
      end
    end
  end

  // captures ram, indirect space or pins, whichever the access used
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rdata_ff <= 8'h00;
    end else if (state_ff == S_CAP) begin
      rdata_ff <= (tgt_stk_ff && !tgt_ext_stack_enable_ff) ? INTERNAL_INDIRECT_SPACE_RDATA_I : ram_rdata;
    end else if (state_ff == S_XSTB && cnt_last && !wr_ff) begin
      rdata_ff <= EXT_DATA_I;
    end
  end

  assign ram_en = state_ff == S_RAM;

  eds_aux_ram #(.AW(ERAM_AW), .DW(8)) u_ram (
    .clk_i(SYS_CLK_I),
    .en_i(ram_en),
    .we_i(wr_ff),
    .addr_i(addr_ff[ERAM_AW-1:0]),
    .wdata_i(wdata_ff),
    .rdata_o(ram_rdata)
  );

  assign READY_O = state_ff == S_IDLE;
  assign XDONE_O = (state_ff == S_DONE) & ~tgt_stk_ff;
  assign STK_DONE_O = (state_ff == S_DONE) & tgt_stk_ff;
  assign XRDATA_O = rdata_ff;
  assign STK_RDATA_O = rdata_ff;
  assign INTERNAL_INDIRECT_SPACE_REQ_O = state_ff == S_IDAT;
  assign INTERNAL_INDIRECT_SPACE_WE_O = (state_ff == S_IDAT) & wr_ff;
  assign INTERNAL_INDIRECT_SPACE_ADDR_O = addr_ff[7:0];
  assign INTERNAL_INDIRECT_SPACE_WDATA_O = wdata_ff;
  assign EXT_ADDR_O = addr_ff;
  assign EXT_RD_N_O = ~((state_ff == S_XSTB) & ~wr_ff);
  assign EXT_WR_N_O = ~((state_ff == S_XSTB) & wr_ff);
  assign EXT_DATA_O = wdata_ff;
  assign EXT_DATA_OE_O = (state_ff == S_XSTB) & wr_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [3:0] stb_cnt_ff;
  logic [3:0] stb_len_ff;
  logic strobe_on;

  assign strobe_on = ~(EXT_RD_N_O & EXT_WR_N_O);

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      stb_cnt_ff <= 4'h0;
      stb_len_ff <= 4'h0;
    end else begin
      stb_cnt_ff <= strobe_on ? stb_cnt_ff + 4'h1 : 4'h0;
      if (acc_mv) stb_len_ff <= strobe_len;
    end
  end

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RSTN_I);

  sequence s_wait_two;
    !XDONE_O ##1 !XDONE_O;
  endsequence

  sequence s_ext_stack_enable_access;
    !STK_DONE_O [*3] ##1 STK_DONE_O;
  endsequence

  a_ws1_forced: assert property (
    COMPAT_MODE_I |-> (strobe_len == STB_COMPAT_WS0 ||
                       strobe_len == STB_COMPAT_WS1) && !ws_eff[1])
    else $error("upper wait bit active in compatibility mode");

  a_strobe_len: assert property (
    $fell(strobe_on) |-> stb_cnt_ff == $past(stb_len_ff))
    else $error("external strobe width wrong");

  // checks the registered target, so a broken capture path is caught too
  a_size_limit: assert property (
    acc_mv && mv_internal |=> !tgt_ext_ff &&
      addr_ff < {4'h0, SZ_1152} && addr_ff < $past({4'h0, size_lim}))
    else $error("internal hit above configured size");

  a_bypass_ext: assert property (
    acc_mv && internal_ram_bypass |=> tgt_ext_ff)
    else $error("bypass move reached internal ram");

  a_page_high: assert property (
    acc_mv && !XWIDE_I && !page_in_range |=>
      tgt_ext_ff && addr_ff[15:8] == $past(P2_LATCH_I))
    else $error("high page move not external on port 2");

  a_nv_window: assert property (
    acc_mv && XWIDE_I && NV_WINDOW_ENABLE_I |=> tgt_ext_ff)
    else $error("nv window move reached internal ram");

  a_eram_min: assert property (
    acc_mv && mv_internal |=> s_wait_two ##1 XDONE_O)
    else $error("internal ram move not done in three cycles");

  a_ext_stack_enable_penalty: assert property (
    acc_stk && ext_stack_enable_ff |=> s_ext_stack_enable_access)
    else $error("extended stack access lacks extra cycle");

  a_spx_held: assert property (
    acc_stk && !ext_stack_enable_ff |=>
      stack_ptr_high_ff == $past(stack_ptr_high_ff))
    else $error("high stack pointer moved in internal stack mode");

  a_stk_internal: assert property (
    tgt_stk_ff |-> EXT_RD_N_O && EXT_WR_N_O)
    else $error("stack access drove external strobe");

  a_ptr_carry: assert property (
    acc_stk && ext_stack_enable_ff && STK_PUSH_I |=>
      {stack_ptr_high_ff, stack_ptr_low_ff} ==
      $past(xptr) + 11'h001)
    else $error("combined stack pointer did not carry");
endmodule : eds_decode

// ==== hdl/eds_pkg.sv ====
package eds_pkg;
  localparam logic [7:0] SFR_AUX_CTRL = 8'h8E;
  localparam logic [7:0] SFR_AUX_CTRL2 = 8'hA2;
  localparam logic [7:0] SFR_PAGE = 8'hF6;
  localparam logic [7:0] SFR_SPX = 8'hEF;
  localparam logic [7:0] SFR_SP = 8'h81;
  localparam logic [7:0] AUX_CTRL_RST = 8'h08;
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [7:0] SP_RST = 8'h07;
  localparam logic [2:0] SPX_RST = 3'h0;
  localparam int WS1_BIT = 6;
  localparam int WS0_BIT = 5;
  localparam int XRS_LSB = 2;
  localparam int BYPASS_BIT = 1;
  localparam int EXT_STACK_ENABLE_BIT = 4;
  localparam logic [7:0] PAGE_MAX = 8'h07;
  localparam logic [2:0] XRS_256 = 3'h0;
  localparam logic [2:0] XRS_512 = 3'h1;
  localparam logic [2:0] XRS_768 = 3'h2;
  localparam logic [2:0] XRS_1024 = 3'h3;
  localparam logic [2:0] XRS_1152 = 3'h4;
  localparam logic [11:0] SZ_256 = 12'h100;
  localparam logic [11:0] SZ_512 = 12'h200;
  localparam logic [11:0] SZ_768 = 12'h300;
  localparam logic [11:0] SZ_1024 = 12'h400;
  localparam logic [11:0] SZ_1152 = 12'h480;
  localparam logic [11:0] SZ_NONE = 12'h000;
  localparam logic [3:0] STB_FAST_BASE = 4'h1;
  localparam logic [3:0] STB_COMPAT_WS0 = 4'h3;
  localparam logic [3:0] STB_COMPAT_WS1 = 4'hF;
  localparam int ERAM_AW = 11;
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_RAM = 7'h02,
    S_CAP = 7'h04,
    S_XSTB = 7'h08,
    S_PEN = 7'h10,
    S_IDAT = 7'h20,
    S_DONE = 7'h40
  } eds_state_e;
endpackage : eds_pkg

// ==== hdl/eds_aux_ram.sv ====
`timescale 1ns/1ns
module eds_aux_ram #(
  parameter int AW = 11,
  parameter int DW = 8
) (
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] rdata_ff;

  // no reset on the array so it maps onto a plain ram macro
  always_ff @(posedge clk_i) begin
    if (en_i) begin
      if (we_i) begin
        mem[addr_i] <= wdata_i;
      end
      rdata_ff <= mem[addr_i];
    end
  end

  assign rdata_o = rdata_ff;
endmodule : eds_aux_ram

// ==== hdl/eds_wait_cnt.sv ====
`timescale 1ns/1ns
module eds_wait_cnt #(
  parameter int W = 4
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic load_i,
  input wire logic [W-1:0] load_val_i,
  input wire logic run_i,
  output logic last_o
);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  assign nxt_cnt = load_i ? load_val_i :
                   (run_i && cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;
  assign last_o = run_i && (cnt_ff == {{(W-1){1'b0}}, 1'b1});

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule : eds_wait_cnt

// ==== test/eds_far_mem.sv ====
`timescale 1ns/1ns
module eds_far_mem (
  input wire logic clk_i,
  input wire logic [15:0] xa_i,
  input wire logic xrd_n_i,
  input wire logic xwr_n_i,
  input wire logic [7:0] xd_i,
  input wire logic xoe_i,
  output logic [7:0] xd_o,
  input wire logic ireq_i,
  input wire logic iwe_i,
  input wire logic [7:0] ia_i,
  input wire logic [7:0] id_i,
  output logic [7:0] id_o
);
  logic [7:0] xmem [0:65535];
  logic [7:0] imem [0:255];
  logic [7:0] last_ff = 8'h00;
  logic [7:0] ird_ff = 8'h00;
  // a released bus shows the inverse of its last value, never a held copy
  assign xd_o = xrd_n_i ? ~last_ff : xmem[xa_i];
  assign id_o = ird_ff;
  always @(posedge clk_i) begin
    if (!xrd_n_i) last_ff <= xmem[xa_i];
    if (!xwr_n_i && xoe_i) xmem[xa_i] <= xd_i;
    if (ireq_i && iwe_i) imem[ia_i] <= id_i;
    // read data is good only in the cycle after the request
    ird_ff <= ireq_i ? imem[ia_i] : ~ird_ff;
  end
endmodule : eds_far_mem

// ==== test/aux_internal_ram_decode_extended_stack_bench.sv ====
`timescale 1ns/1ns
module aux_internal_ram_decode_extended_stack_bench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic swr = 1'b0, srd = 1'b0, compat = 1'b0, nv = 1'b0;
  logic xreq = 1'b0, xw = 1'b0, xwr = 1'b0, kreq = 1'b0, kpush = 1'b0;
  logic [7:0] sa = 8'h00, swd = 8'h00, p2 = 8'h00;
  logic [7:0] xa8 = 8'h00, xwd = 8'h00;
  logic [15:0] xa16 = 16'h0000;
  logic [7:0] srdat, xrdat, krdat, ia, iwd, ird, edo, edi, v, rd;
  logic xdone, kdone, ireq, iwe, erd_n, ewr_n, eoe, rdy;
  logic [15:0] ea, ad, n, stb, ci;
  logic [15:0] idq = 16'h0000;
  int error_cnt = 0;
  int n_checks = 0;

  eds_decode dut (
    .SYS_CLK_I(clk), .RSTN_I(rstn), .SFR_ADDR_I(sa), .SFR_WR_I(swr),
    .SFR_RD_I(srd), .SFR_WDATA_I(swd), .SFR_RDATA_O(srdat),
    .COMPAT_MODE_I(compat), .NV_WINDOW_ENABLE_I(nv), .P2_LATCH_I(p2),
    .XREQ_I(xreq), .XWIDE_I(xw), .XWR_I(xwr), .XADDR16_I(xa16),
    .XADDR8_I(xa8), .XWDATA_I(xwd), .XDONE_O(xdone), .XRDATA_O(xrdat),
    .STK_REQ_I(kreq), .STK_PUSH_I(kpush), .STK_WDATA_I(xwd),
    .STK_DONE_O(kdone), .STK_RDATA_O(krdat), .READY_O(rdy),
    .INTERNAL_INDIRECT_SPACE_REQ_O(ireq), .INTERNAL_INDIRECT_SPACE_WE_O(iwe), .INTERNAL_INDIRECT_SPACE_ADDR_O(ia),
    .INTERNAL_INDIRECT_SPACE_WDATA_O(iwd), .INTERNAL_INDIRECT_SPACE_RDATA_I(ird), .EXT_ADDR_O(ea),
    .EXT_RD_N_O(erd_n), .EXT_WR_N_O(ewr_n), .EXT_DATA_O(edo),
    .EXT_DATA_OE_O(eoe), .EXT_DATA_I(edi)
  );
  eds_far_mem far (
    .clk_i(clk), .xa_i(ea), .xrd_n_i(erd_n), .xwr_n_i(ewr_n),
    .xd_i(edo), .xoe_i(eoe), .xd_o(edi), .ireq_i(ireq), .iwe_i(iwe),
    .ia_i(ia), .id_i(iwd), .id_o(ird)
  );

  always #50 clk = ~clk;
  always @(posedge clk) if (ireq) idq <= idq + 16'h0001;
  initial begin
    // more than a hundred times the expected run
    #3000000;
    error_cnt++;
    results();
  end
////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic sfr(input logic wr, input logic [7:0] a,
    input logic [7:0] d = 8'h00);
    @(posedge clk) #1;
    sa = a;
    swd = d;
    swr = wr;
    srd = !wr;
    @(posedge clk) #1;
    swr = 1'b0;
    srd = 1'b0;
    v = srdat;
  endtask : sfr

  // k selects a stack operation, wr doubles as push
  task automatic op(input logic k, input logic w, input logic wr,
    input logic [15:0] a, input logic [7:0] a8 = 8'h00,
    input logic [7:0] d = 8'h00);
    @(posedge clk) #1;
    chk(rdy, 1'b1);
    xw = w;
    xwr = wr;
    kpush = wr;
    xa16 = a;
    xa8 = a8;
    xwd = d;
    xreq = !k;
    kreq = k;
    n = 16'h0000;
    stb = 16'h0000;
    do begin
      @(posedge clk) #1;
      xreq = 1'b0;
      kreq = 1'b0;
      n++;
      if (!erd_n || !ewr_n) begin
        stb++;
        ad = ea;
      end
    end while (!(k ? kdone : xdone) && n < 16'h0028);
    // a run-out of the cycle limit lands here as a mismatch
    chk(k ? kdone : xdone, 1'b1);
    rd = k ? krdat : xrdat;
  endtask : op
////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] ra [5] = '{8'h8E, 8'hF6, 8'h81, 8'hEF, 8'h55};
    logic [7:0] re [5] = '{8'h08, 8'h00, 8'h07, 8'h00, 8'h00};
    foreach (ra[i]) begin
      sfr(1'b0, ra[i]);
      chk(v, re[i]);
    end
    compat = 1'b1;
    sfr(1'b1, 8'h8E, 8'h68);
    sfr(1'b0, 8'h8E);
    chk(v, 8'h28);
    compat = 1'b0;
    sfr(1'b0, 8'h8E);
    chk(v, 8'h68);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_size();
    logic [15:0] sz [5] = '{16'h0100, 16'h0200, 16'h0300, 16'h0400,
      16'h0480};
    for (int c = 0; c < 8; c++) begin
      sfr(1'b1, 8'h8E, {3'h0, c[2:0], 2'h0});
      if (c < 5) begin
        op(1'b0, 1'b1, 1'b0, sz[c] - 16'h0001);
        chk(stb, 16'h0000);
        op(1'b0, 1'b1, 1'b0, sz[c]);
      end else begin
        op(1'b0, 1'b1, 1'b0, 16'h0000);
      end
      chk(stb, 16'h0001);
    end
    $display("t_size done");
  endtask : t_size

  task automatic t_wait();
    logic [15:0] e;
    for (int m = 0; m < 8; m++) begin
      compat = m[2];
      sfr(1'b1, 8'h8E, {1'b0, m[1:0], 5'h08});
      e = m[2] ? (m[0] ? 16'h000F : 16'h0003) : {14'h0, m[1:0]} + 16'h1;
      op(1'b0, 1'b1, 1'b0, 16'h0400);
      chk(stb, e);
    end
    compat = 1'b0;
    sfr(1'b1, 8'h8E, 8'h08);
    $display("t_wait done");
  endtask : t_wait

  task automatic t_map();
    op(1'b0, 1'b1, 1'b1, 16'h0010, 8'h00, 8'hA5);
    chk(stb, 16'h0000);
    chk(n >= 16'h0003, 1'b1);
    op(1'b0, 1'b1, 1'b0, 16'h0010);
    chk(rd, 8'hA5);
    nv = 1'b1;
    op(1'b0, 1'b1, 1'b0, 16'h0010);
    chk(stb, 16'h0001);
    op(1'b0, 1'b0, 1'b0, 16'h0000, 8'h10);
    chk(rd, 8'hA5);
    nv = 1'b0;
    sfr(1'b1, 8'h8E, 8'h0A);
    op(1'b0, 1'b1, 1'b1, 16'h0010, 8'h00, 8'hC3);
    chk(far.xmem[16'h0010], 8'hC3);
    op(1'b0, 1'b1, 1'b0, 16'hFFFF);
    chk(ad, 16'hFFFF);
    sfr(1'b1, 8'h8E, 8'h08);
    $display("t_map done");
  endtask : t_map

  task automatic t_page();
    sfr(1'b1, 8'hF6, 8'h02);
    op(1'b0, 1'b0, 1'b1, 16'h0000, 8'h34, 8'h77);
    chk(stb, 16'h0000);
    op(1'b0, 1'b1, 1'b0, 16'h0234);
    chk(rd, 8'h77);
    p2 = 8'hAB;
    sfr(1'b1, 8'hF6, 8'h08);
    op(1'b0, 1'b0, 1'b0, 16'h0000, 8'h12);
    chk(ad, 16'hAB12);
    sfr(1'b1, 8'hF6, 8'h00);
    $display("t_page done");
  endtask : t_page

  task automatic t_stk();
    sfr(1'b1, 8'hEF, 8'h05);
    op(1'b1, 1'b0, 1'b1, 16'h0000, 8'h00, 8'h5A);
    chk(far.imem[8], 8'h5A);
    op(1'b1, 1'b0, 1'b0, 16'h0000);
    chk(rd, 8'h5A);
    ci = n;
    sfr(1'b1, 8'hA2, 8'h10);
    sfr(1'b1, 8'h8E, 8'h0A);
    sfr(1'b1, 8'hEF, 8'h00);
    sfr(1'b1, 8'h81, 8'hFF);
    ci = ci - idq;
    op(1'b1, 1'b0, 1'b1, 16'h0000, 8'h00, 8'h3C);
    sfr(1'b0, 8'hEF);
    chk(v, 8'h01);
    op(1'b1, 1'b0, 1'b0, 16'h0000);
    chk(rd, 8'h3C);
    chk(stb, 16'h0000);
    chk(n - ci - idq, 16'h0001);
    sfr(1'b0, 8'h81);
    chk(v, 8'hFF);
    sfr(1'b1, 8'hA2, 8'h00);
    sfr(1'b1, 8'h8E, 8'h08);
    op(1'b0, 1'b1, 1'b0, 16'h0100);
    chk(rd, 8'h3C);
    $display("t_stk done");
  endtask : t_stk

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  initial begin
    repeat (8) @(posedge clk);
    #1;
    rstn = 1'b1;
    t_regs();
    t_size();
    t_wait();
    t_map();
    t_page();
    t_stk();
    results();
  end
endmodule : aux_internal_ram_decode_extended_stack_bench
